/* hdl/scdp_pkg.sv */
// shared constants and types for the serial clock rate and data path block
package scdp_pkg;

    // system clock
    localparam int CLK_HZ = 40_000_000;
    localparam int T_SYSTEM_CLOCK_NS = 25;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIVISOR = 8'hA2;
    localparam logic [7:0] IDX_DATA = 8'hA3;
    localparam logic [7:0] IDX_CTRL = 8'hA4;
    localparam logic [7:0] IDX_STATUS = 8'hA5;
    localparam int ADDR_W = 12;

    // values after reset
    localparam logic [7:0] DIVISOR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [3:0] PIN_RST = 4'h8;

    // status register bit positions
    localparam int STAT_DONE_BIT = 7;
    localparam int STAT_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int STAT_OVR_BIT = 4;
    localparam int STAT_RXNE_BIT = 2;
    localparam int STAT_TXE_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;

    // synchronised pin vector positions
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SS = 3;

    // data path sizes
    localparam int BYTE_W = 8;
    localparam int RX_FIFO_DEPTH = 32;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // slave timing, times in system clock periods
    localparam int SYNC_STAGES = 3;
    localparam int SLH_MIN_PERIODS = 6;
    localparam int SLH_MAX_PERIODS = 8;
    localparam int SLH_MIN_CYC = (SLH_MIN_PERIODS * T_SYSTEM_CLOCK_NS + T_SYSTEM_CLOCK_NS - 1) / T_SYSTEM_CLOCK_NS;
    localparam logic [3:0] SLH_WAIT_CYC = 4'(SLH_MIN_CYC - SYNC_STAGES);

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } scdp_apb_req_type;

    // control register layout
    typedef struct packed {
        logic cpha;
        logic cpol;
        logic master;
        logic enable;
    } scdp_ctrl_type;

    typedef enum logic [1:0] {ST_IDLE, ST_MRUN, ST_SLAVE} scdp_state_type;

endpackage : scdp_pkg

/* hdl/scdp_fifo.sv */
// receive fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module scdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    import scdp_pkg::*;

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // pointer and level bookkeeping
    always_comb
    begin
        push = in_valid_i && (cnt_r != (AW+1)'(DEPTH));
        pop = out_ready_i && (cnt_r != '0);
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
        cnt_nxt = cnt_r;
        if (push && !pop)
        begin
            cnt_nxt = cnt_r + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end
        else if (ce_i)
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage has no reset; only written slots are ever read
    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
        begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rd_ptr_r];

endmodule : scdp_fifo
`default_nettype wire

/* hdl/scdp_core.sv */
// serial clock divider, data register and shift engine with apb registers
`timescale 1ns/1ps
`default_nettype none
module scdp_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire scdp_pkg::scdp_apb_req_type apb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic slave_select_n_i,
    output logic sck_o,
    output logic sck_oe_o,
    output logic mosi_o,
    output logic mosi_oe_o,
    output logic miso_o,
    output logic miso_oe_o,
    output logic transfer_done_flag_o
);
    import scdp_pkg::*;

    // pin synchronisers
    logic [3:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r, pin_eff, pin_q_nxt;

    // register file state
    logic [7:0] div_r, div_nxt, tx_buf_r, tx_buf_nxt;
    scdp_ctrl_type ctl_r, ctl_nxt;
    logic txe_r, txe_nxt, done_r, done_nxt, write_collision_flag_r, write_collision_flag_nxt, ovr_r, ovr_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    // engine state
    scdp_state_type st_r, st_nxt;
    logic ph_r, ph_nxt, sck_r, sck_nxt, lat_r, lat_nxt, out_r, out_nxt;
    logic sck_oe_r, sck_oe_nxt, mosi_oe_r, mosi_oe_nxt, miso_oe_r, miso_oe_nxt;
    logic [7:0] hcnt_r, hcnt_nxt, sh_r, sh_nxt, rx_byte;
    logic [2:0] bit_r, bit_nxt;
    logic [3:0] slh_r, slh_nxt;
    logic lead, trail, in_bit, sp_now, sp_old;
    logic done_ev, load_ev, ovr_ev, push_vld;

    // apb decode and fifo handshake
    logic setup, acc_wr, acc_rd, hit, wr_take, write_collision_flag_set;
    logic clr_done, clr_write_collision_flag, clr_ovr;
    logic [7:0] idx;
    logic fifo_in_rdy, fifo_out_vld, fifo_pop;
    logic [7:0] fifo_out_data;

    // a change counts once stages two and three agree
    always_comb
    begin
        pin_eff = (pin_q_r & (pin_s2_r ^ pin_s3_r)) | (pin_s3_r & ~(pin_s2_r ^ pin_s3_r));
        pin_q_nxt = pin_eff;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_s1_r <= PIN_RST;
            pin_s2_r <= PIN_RST;
            pin_s3_r <= PIN_RST;
            pin_q_r <= PIN_RST;
        end
        else if (ce_i)
        begin
            pin_s1_r <= {slave_select_n_i, miso_i, mosi_i, sck_i};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_q_r <= pin_q_nxt;
        end
    end

    // shift engine: master clock generation and slave edge tracking
    always_comb
    begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        hcnt_nxt = hcnt_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        lat_nxt = lat_r;
        out_nxt = out_r;
        slh_nxt = slh_r;
        miso_oe_nxt = miso_oe_r;
        lead = 1'b0;
        trail = 1'b0;
        done_ev = 1'b0;
        load_ev = 1'b0;
        ovr_ev = 1'b0;
        push_vld = 1'b0;
        rx_byte = sh_r;
        in_bit = ctl_r.master ? pin_eff[PIN_MISO] : pin_eff[PIN_MOSI];
        sp_now = pin_eff[PIN_SCK] ^ ctl_r.cpol;
        sp_old = pin_q_r[PIN_SCK] ^ ctl_r.cpol;
        // delayed output change after the closing edge in phase one
        if (slh_r != 4'h0)
        begin
            slh_nxt = slh_r - 4'h1;
            if (slh_r == 4'h1)
            begin
                out_nxt = sh_r[7];
            end
        end
        case (st_r)
            ST_IDLE:
            begin
                ph_nxt = 1'b0;
                hcnt_nxt = 8'h00;
                bit_nxt = 3'h0;
                if (ctl_r.enable && ctl_r.master && !txe_r && fifo_in_rdy)
                begin
                    load_ev = 1'b1;
                    sh_nxt = tx_buf_r;
                    out_nxt = tx_buf_r[7];
                    st_nxt = ST_MRUN;
                end
                else if (ctl_r.enable && !ctl_r.master && !pin_eff[PIN_SS])
                begin
                    st_nxt = ST_SLAVE;
                    miso_oe_nxt = 1'b1;
                    slh_nxt = 4'h0;
                    load_ev = !txe_r;
                    sh_nxt = txe_r ? sh_r : tx_buf_r;
                    out_nxt = txe_r ? sh_r[7] : tx_buf_r[7];
                end
            end
            ST_MRUN:
            begin
                // half period of divisor+1 cycles gives the documented rate
                if (hcnt_r == div_r)
                begin
                    hcnt_nxt = 8'h00;
                    ph_nxt = !ph_r;
                    lead = !ph_r;
                    trail = ph_r;
                end
                else
                begin
                    hcnt_nxt = hcnt_r + 8'h01;
                end
            end
            ST_SLAVE:
            begin
                if (pin_eff[PIN_SS])
                begin
                    st_nxt = ST_IDLE;
                    miso_oe_nxt = 1'b0;
                    slh_nxt = 4'h0;
                end
                else
                begin
                    lead = sp_now && !sp_old;
                    trail = !sp_now && sp_old;
                end
            end
            default:
            begin
                st_nxt = ST_IDLE;
            end
        endcase
        // phase zero samples on leading edge, phase one shifts on it
        if (lead)
        begin
            if (ctl_r.cpha)
            begin
                out_nxt = sh_r[7];
            end
            else
            begin
                lat_nxt = in_bit;
            end
        end
        if (trail)
        begin
            rx_byte = {sh_r[6:0], ctl_r.cpha ? in_bit : lat_r};
            sh_nxt = rx_byte;
            out_nxt = ctl_r.cpha ? out_r : sh_r[6];
            bit_nxt = bit_r + 3'h1;
            if (bit_r == LAST_BIT)
            begin
                done_ev = 1'b1;
                push_vld = fifo_in_rdy;
                ovr_ev = (st_r == ST_SLAVE) && !fifo_in_rdy;
                if (st_r == ST_MRUN)
                begin
                    st_nxt = ST_IDLE;
                end
                else
                begin
                    // slave keeps going; next byte preloads at once
                    load_ev = !txe_r;
                    sh_nxt = txe_r ? rx_byte : tx_buf_r;
                    if (ctl_r.cpha)
                    begin
                        slh_nxt = SLH_WAIT_CYC;
                    end
                    else
                    begin
                        out_nxt = sh_nxt[7];
                    end
                end
            end
        end
        // disabling aborts any byte in flight without side effects
        if (!ctl_r.enable)
        begin
            st_nxt = ST_IDLE;
            ph_nxt = 1'b0;
            miso_oe_nxt = 1'b0;
            slh_nxt = 4'h0;
            done_ev = 1'b0;
            load_ev = 1'b0;
            ovr_ev = 1'b0;
            push_vld = 1'b0;
        end
        sck_nxt = ph_nxt ^ ctl_r.cpol;
        sck_oe_nxt = ctl_r.enable && ctl_r.master;
        mosi_oe_nxt = ctl_r.enable && ctl_r.master;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r <= ST_IDLE;
            ph_r <= 1'b0;
            sck_r <= 1'b0;
            hcnt_r <= 8'h00;
            bit_r <= 3'h0;
            sh_r <= DATA_RST;
            lat_r <= 1'b0;
            out_r <= 1'b0;
            slh_r <= 4'h0;
            sck_oe_r <= 1'b0;
            mosi_oe_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            sck_r <= sck_nxt;
            hcnt_r <= hcnt_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            lat_r <= lat_nxt;
            out_r <= out_nxt;
            slh_r <= slh_nxt;
            sck_oe_r <= sck_oe_nxt;
            mosi_oe_r <= mosi_oe_nxt;
            miso_oe_r <= miso_oe_nxt;
        end
    end

    // received bytes queue here; a full queue holds off the master
    scdp_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .in_valid_i(push_vld),
        .in_ready_o(fifo_in_rdy),
        .in_data_i(rx_byte),
        .out_valid_o(fifo_out_vld),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out_data)
    );

    // apb slave: zero wait states, read data captured in setup
    always_comb
    begin
        idx = apb_i.paddr[9:2];
        hit = (apb_i.paddr[11:10] == 2'b00) && (apb_i.paddr[1:0] == 2'b00)
            && ((idx == IDX_DIVISOR) || (idx == IDX_DATA) || (idx == IDX_CTRL)
            || (idx == IDX_STATUS));
        setup = apb_i.psel && !apb_i.penable;
        acc_wr = apb_i.psel && apb_i.penable && pready_r && apb_i.pwrite && hit;
        acc_rd = apb_i.psel && apb_i.penable && pready_r && !apb_i.pwrite && hit;
        fifo_pop = acc_rd && (idx == IDX_DATA) && fifo_out_vld;
        pready_nxt = setup;
        pslverr_nxt = setup && !hit;
        prdata_nxt = prdata_r;
        div_nxt = div_r;
        ctl_nxt = ctl_r;
        tx_buf_nxt = tx_buf_r;
        wr_take = 1'b0;
        write_collision_flag_set = 1'b0;
        clr_done = 1'b0;
        clr_write_collision_flag = 1'b0;
        clr_ovr = 1'b0;
        if (setup)
        begin
            prdata_nxt = 32'h0000_0000;
            case (idx)
                IDX_DIVISOR: prdata_nxt[7:0] = div_r;
                IDX_DATA: prdata_nxt[7:0] = fifo_out_vld ? fifo_out_data : DATA_RST;
                IDX_CTRL: prdata_nxt[3:0] = ctl_r;
                IDX_STATUS:
                begin
                    prdata_nxt[STAT_DONE_BIT] = done_r;
                    prdata_nxt[STAT_WRITE_COLLISION_FLAG_BIT] = write_collision_flag_r;
                    prdata_nxt[STAT_OVR_BIT] = ovr_r;
                    prdata_nxt[STAT_RXNE_BIT] = fifo_out_vld;
                    prdata_nxt[STAT_TXE_BIT] = txe_r;
                    prdata_nxt[STAT_BUSY_BIT] = (st_r != ST_IDLE);
                end
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
        if (acc_wr)
        begin
            case (idx)
                IDX_DIVISOR: div_nxt = apb_i.pwdata[7:0];
                IDX_DATA:
                begin
                    if (txe_r)
                    begin
                        tx_buf_nxt = apb_i.pwdata[7:0];
                        wr_take = 1'b1;
                    end
                    else
                    begin
                        write_collision_flag_set = 1'b1;
                    end
                end
                IDX_CTRL: ctl_nxt = scdp_ctrl_type'(apb_i.pwdata[3:0]);
                IDX_STATUS:
                begin
                    clr_done = apb_i.pwdata[STAT_DONE_BIT];
                    clr_write_collision_flag = apb_i.pwdata[STAT_WRITE_COLLISION_FLAG_BIT];
                    clr_ovr = apb_i.pwdata[STAT_OVR_BIT];
                end
                default: div_nxt = div_r;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        done_nxt = done_ev || (done_r && !clr_done);
        write_collision_flag_nxt = write_collision_flag_set || (write_collision_flag_r && !clr_write_collision_flag);
        ovr_nxt = ovr_ev || (ovr_r && !clr_ovr);
        txe_nxt = load_ev ? 1'b1 : (wr_take ? 1'b0 : txe_r);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_r <= DIVISOR_RST;
            ctl_r <= CTRL_RST;
            tx_buf_r <= DATA_RST;
            txe_r <= 1'b1;
            done_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            ovr_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            div_r <= div_nxt;
            ctl_r <= ctl_nxt;
            tx_buf_r <= tx_buf_nxt;
            txe_r <= txe_nxt;
            done_r <= done_nxt;
            write_collision_flag_r <= write_collision_flag_nxt;
            ovr_r <= ovr_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // every output straight from a flop
    assign pready_o = pready_r;
    assign prdata_o = prdata_r;
    assign pslverr_o = pslverr_r;
    assign sck_o = sck_r;
    assign sck_oe_o = sck_oe_r;
    assign mosi_o = out_r;
    assign mosi_oe_o = mosi_oe_r;
    assign miso_o = out_r;
    assign miso_oe_o = miso_oe_r;
    assign transfer_done_flag_o = done_r;

    // checks, frozen while the clock enable is low
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || !ce_i);

    sequence slave_byte_end_s;
        (st_r == ST_SLAVE) && done_ev && ctl_r.cpha && ctl_r.enable;
    endsequence

    sequence out_held_s;
        $stable(out_r) [*3];
    endsequence

    divider_rate_a: assert property ((st_r == ST_MRUN) && (hcnt_r != div_r) && ctl_r.enable
        |=> $stable(sck_r)) else $error("serial clock moved before divisor count");
    divisor_write_a: assert property (acc_wr && (idx == IDX_DIVISOR)
        |=> div_r == $past(apb_i.pwdata[7:0])) else $error("divisor write lost");
    tx_load_a: assert property (acc_wr && (idx == IDX_DATA) && txe_r && !load_ev
        |=> !txe_r && (tx_buf_r == $past(apb_i.pwdata[7:0]))) else $error("data write not loaded");
    rx_read_a: assert property (setup && (idx == IDX_DATA) && fifo_out_vld && hit
        |=> prdata_r[7:0] == $past(fifo_out_data)) else $error("read data not buffer head");
    idle_polarity_a: assert property ((st_r == ST_IDLE) ##1 (st_r == ST_IDLE)
        |-> sck_r == $past(ctl_r.cpol)) else $error("idle clock level wrong");
    select_drive_a: assert property ($fell(pin_q_r[PIN_SS]) && ctl_r.enable && !ctl_r.master
        && $past(st_r == ST_IDLE) |-> miso_oe_r) else $error("slave output not driven");
    select_release_a: assert property ($rose(pin_q_r[PIN_SS]) && $past(st_r == ST_SLAVE)
        |-> !miso_oe_r) else $error("slave output not released");
    late_change_a: assert property (slave_byte_end_s ##1 (slh_r == SLH_WAIT_CYC)
        |-> out_held_s ##0 (slh_r == 4'h1) ##1 (out_r == $past(sh_r[7])))
        else $error("phase one late change mistimed");
    done_sticky_a: assert property ($fell(done_r) |-> $past(clr_done) && !$past(done_ev))
        else $error("done flag cleared without software");
    collision_a: assert property (acc_wr && (idx == IDX_DATA) && !txe_r
        |=> write_collision_flag_r && $stable(tx_buf_r)) else $error("collision not flagged");
    empty_set_a: assert property (load_ev |=> txe_r)
        else $error("empty flag not set on move");
    overrun_a: assert property ((st_r == ST_SLAVE) && done_ev && !fifo_in_rdy && ctl_r.enable
        |=> ovr_r) else $error("overrun not flagged");

endmodule : scdp_core
`default_nettype wire

/* bench/scdp_peer.sv */
// external serial partner: slave in master mode, master in slave mode
`timescale 1ns/1ps
`default_nettype none
module scdp_peer (
    input wire logic clk_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic mosi_oe_i,
    input wire logic miso_i,
    input wire logic miso_oe_i,
    output logic sck_o,
    output logic mosi_o,
    output logic miso_o,
    output logic slave_select_n_o
);
    logic [7:0] shreg_r = 8'h00;
    logic cap_r = 1'b0;
    initial
    begin
        sck_o = 1'b0;
        mosi_o = 1'b0;
        slave_select_n_o = 1'b1;
    end
    assign miso_o = shreg_r[7];
    // slave side, phase 0: sample on leading edge, shift on trailing
    // reacts on the clock edge itself, as a real slave does; a system
    // clock of delay here would eat the master's synchroniser margin
    always @(posedge sck_i)
    begin
        if (mosi_oe_i)
            cap_r <= mosi_i;
    end
    always @(negedge sck_i)
    begin
        if (mosi_oe_i)
            shreg_r <= {shreg_r[6:0], cap_r};
    end
    // master side, polarity 0, either phase; slow clock of 6 cycles per half
    task automatic xfer(input logic cpha, input logic [7:0] tx, output logic [7:0] rx,
        output logic oe_ok);
        rx = 8'h00;
        @(posedge clk_i);
        slave_select_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        oe_ok = miso_oe_i;
        for (int i = 7; i >= 0; i--)
        begin
            if (!cpha)
                mosi_o <= tx[i];
            repeat (6) @(posedge clk_i);
            sck_o <= 1'b1;
            if (cpha)
                mosi_o <= tx[i];
            else
                rx = {rx[6:0], miso_i};
            repeat (6) @(posedge clk_i);
            sck_o <= 1'b0;
            if (cpha)
                rx = {rx[6:0], miso_i};
        end
        repeat (3) @(posedge clk_i);
        slave_select_n_o <= 1'b1;
        mosi_o <= ~tx[0];
        repeat (4) @(posedge clk_i);
    endtask : xfer
endmodule : scdp_peer
`default_nettype wire

/* bench/spi_clock_rate_and_data_path_tb_top.sv */
// self-checking bench for the serial clock rate and data path block
`timescale 1ns/1ps
`default_nettype none
module spi_clock_rate_and_data_path_tb_top;
    import scdp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    scdp_apb_req_type req = '0;
    logic pready, pslverr, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, done, last_err;
    logic p_sck, p_mosi, p_miso, p_ss_n, oe_ok;
    logic [31:0] prdata, rdv;
    logic [7:0] prx;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    always #12.5 clk_i = ~clk_i;
    scdp_core scdp_core_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .apb_i(req),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .sck_i(p_sck),
        .mosi_i(p_mosi), .miso_i(p_miso), .slave_select_n_i(p_ss_n), .sck_o(sck),
        .sck_oe_o(sck_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe), .miso_o(miso),
        .miso_oe_o(miso_oe), .transfer_done_flag_o(done));
    // slave-out line has a pull-up while released
    scdp_peer scdp_peer_i (.clk_i(clk_i), .sck_i(sck), .mosi_i(mosi), .mosi_oe_i(mosi_oe),
        .miso_i(miso_oe ? miso : 1'b1), .miso_oe_i(miso_oe), .sck_o(p_sck), .mosi_o(p_mosi),
        .miso_o(p_miso), .slave_select_n_o(p_ss_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ADDR_W'({idx, 2'b00}), pwdata: wd};
        @(posedge clk_i);
        req.penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rdv = prdata;
        last_err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic rdm(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(rdv & mask, exp);
    endtask : rdm
    // counts edges while the serial clock stays at one level
    task automatic hold_len(input logic lvl, output int cnt);
        cnt = 0;
        while (sck === lvl && cnt < 600)
        begin
            @(posedge clk_i);
            cnt++;
        end
    endtask : hold_len
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // hang guard, well above the longest expected run
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            err_total++;
            stop_test();
        end
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdm(IDX_DIVISOR, 32'hFFFF_FFFF, 32'h0000_0000);
        rdm(IDX_DATA, 32'hFFFF_FFFF, 32'h0000_0000);
        rdm(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'(last_err), 32'h0000_0001);
        apb(1'b1, IDX_DIVISOR, 32'h0000_00FF);
        rdm(IDX_DIVISOR, 32'hFFFF_FFFF, 32'h0000_00FF);
        $display("test registers finished");
        // slave mode: a discarded second write, then one byte each way
        apb(1'b1, IDX_CTRL, 32'h0000_0001);
        apb(1'b1, IDX_DATA, 32'h0000_0011);
        apb(1'b1, IDX_DATA, 32'h0000_0022);
        rdm(IDX_STATUS, 32'h0000_00FF, 32'h0000_0040);
        scdp_peer_i.xfer(1'b0, 8'h5A, prx, oe_ok);
        chk(32'(oe_ok), 32'h0000_0001);
        chk(32'(prx), 32'h0000_0011);
        repeat (5) @(posedge clk_i);
        chk(32'(miso_oe), 32'h0000_0000);
        chk(32'(done), 32'h0000_0001);
        rdm(IDX_STATUS, 32'h0000_00FF, 32'h0000_00C6);
        apb(1'b1, IDX_STATUS, 32'h0000_00D0);
        rdm(IDX_STATUS, 32'h0000_00FF, 32'h0000_0006);
        rdm(IDX_DATA, 32'h0000_00FF, 32'h0000_005A);
        $display("test slave byte finished");
        // master mode, divisor 3 gives four cycles per half period
        apb(1'b1, IDX_DIVISOR, 32'h0000_0003);
        apb(1'b1, IDX_CTRL, 32'h0000_0003);
        scdp_peer_i.shreg_r = 8'hC3;
        apb(1'b1, IDX_DATA, 32'h0000_0096);
        chk(32'(sck_oe), 32'h0000_0001);
        hold_len(1'b0, n);
        hold_len(1'b1, n);
        chk(n, 32'd4);
        hold_len(1'b0, n);
        chk(n, 32'd4);
        n = 0;
        while (done !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(32'(done), 32'h0000_0001);
        chk(32'(scdp_peer_i.shreg_r), 32'h0000_0096);
        rdm(IDX_DATA, 32'h0000_00FF, 32'h0000_00C3);
        apb(1'b1, IDX_CTRL, 32'h0000_0007);
        repeat (3) @(posedge clk_i);
        chk(32'(sck), 32'h0000_0001);
        apb(1'b1, IDX_CTRL, 32'h0000_0003);
        repeat (3) @(posedge clk_i);
        chk(32'(sck), 32'h0000_0000);
        $display("test master byte finished");
        // slave mode, phase one: output moves on leading edges, late change at end
        apb(1'b1, IDX_CTRL, 32'h0000_0009);
        apb(1'b1, IDX_DATA, 32'h0000_00A5);
        scdp_peer_i.xfer(1'b1, 8'h3C, prx, oe_ok);
        chk(32'(oe_ok), 32'h0000_0001);
        chk(32'(prx), 32'h0000_00A5);
        rdm(IDX_DATA, 32'h0000_00FF, 32'h0000_003C);
        $display("test slave phase one finished");
        // slave mode: fill the receive fifo past full, then drain it
        apb(1'b1, IDX_CTRL, 32'h0000_0001);
        apb(1'b1, IDX_STATUS, 32'h0000_00D0);
        for (int i = 0; i <= RX_FIFO_DEPTH; i++)
        begin
            if (i == RX_FIFO_DEPTH)
                rdm(IDX_STATUS, 32'h0000_0014, 32'h0000_0004);
            scdp_peer_i.xfer(1'b0, 8'(i), prx, oe_ok);
        end
        rdm(IDX_STATUS, 32'h0000_0014, 32'h0000_0014);
        for (int i = 0; i < RX_FIFO_DEPTH; i++)
            rdm(IDX_DATA, 32'h0000_00FF, 32'(i));
        rdm(IDX_STATUS, 32'h0000_0004, 32'h0000_0000);
        $display("test overrun finished");
        stop_test();
    end
endmodule : spi_clock_rate_and_data_path_tb_top
`default_nettype wire
